// ===== fxu_core_model.sv
// Core-side model: answers the software handler request.
// Assumes handlerReq is a level from the unit's state register.
`timescale 1ns/1ps
`default_nettype none
module fxu_core_model (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Synchronous, active high
  input wire logic handlerReq, // Handler invoked by the unit
  input wire logic [3:0] doneDelay, // Handler run length in cycles
  output logic handlerDone // One-cycle end of handler
);
  logic [3:0] waitCnt_reg;
  // Delay is a port so the bench can act as a prompt or a slow handler
  always_ff @(posedge core_clk) begin
    if (reset || !handlerReq || handlerDone) begin
      waitCnt_reg <= 4'h0;
      handlerDone <= 1'b0;
    end else begin
      waitCnt_reg <= waitCnt_reg + 4'h1;
      handlerDone <= (waitCnt_reg == doneDelay);
    end
  end
endmodule : fxu_core_model
`default_nettype wire

// ===== fxu_exception_unit.sv
// Exception flag and mask unit of a stack floating-point unit.
// Assumes the integer core issues one opcode per valid cycle and
// reports datapath conditions in the same cycle; APB reaches state.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fxu_exception_unit
  import fxu_pkg::*;
(
  input wire logic core_clk, // Core clock, 200 MHz
  input wire logic reset, // Synchronous, active high
  input wire logic opValid, // Opcode presented this cycle
  input wire fxu_op_t opcode, // Decoded opcode class
  input wire logic [15:0] opData, // Word loaded by control/restore ops
  input wire logic stackOverflow, // Push onto non-empty register
  input wire logic stackUnderflow, // Read of empty register
  input wire logic invalidOperand, // Invalid arithmetic operand seen
  input wire logic denormOperand, // Denormal operand seen
  input wire logic zeroDivide, // Divide by zero seen
  input wire logic numOverflow, // Result overflow
  input wire logic numUnderflow, // Result underflow
  input wire logic inexactResult, // Result rounded
  input wire logic handlerDone, // Core finished the handler
  output logic storeValid, // Store data valid
  output logic [15:0] storeData, // Word read by store/save ops
  output logic handlerReq, // Software handler invoked
  output logic holdState, // Keep stack pointer and sources
  output logic writeIndefinite, // Write indefinite to destination
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr // APB error
);
  logic [15:0] status_reg;
  logic [15:0] control_reg;
  logic [4:0] lastOp_reg;
  logic [15:0] storeData_reg;
  logic storeValid_reg;
  logic writeIndef_reg;
  fxu_state_t state_reg;
  fxu_state_t state_next;
  logic isArith;
  logic isLegacyNop;
  logic opLive;
  logic stackFault;
  logic [5:0] newExc;
  logic [5:0] unmaskedNew;
  logic [5:0] flagsAfter;
  logic maskLoad;
  logic apbAccess;
  logic apbWrite;
  logic apbClear;
  logic apbCtrlWrite;
  logic mapped;

  fxu_op_classifier u_class (
    .opcode(opcode),
    .isArith(isArith),
    .isLegacyNop(isLegacyNop)
  );

  // Legacy opcodes are dropped before touching any state
  assign opLive = opValid && !isLegacyNop && (state_reg == ST_IDLE);

  // Stack faults do not need an operand, so any non-legacy opcode may raise one
  assign stackFault = opLive && (stackOverflow || stackUnderflow);

  // Operand-derived classes only for the arithmetic class
  always_comb begin
    newExc = 6'h00;
    newExc[ST_INVALID_BIT] = stackFault || (opLive && isArith && invalidOperand);
    newExc[ST_DENORM_BIT] = opLive && isArith && denormOperand;
    newExc[ST_ZERODIV_BIT] = opLive && isArith && zeroDivide;
    newExc[ST_OVERFLOW_BIT] = opLive && isArith && numOverflow;
    newExc[ST_UNDERFLOW_BIT] = opLive && isArith && numUnderflow;
    newExc[ST_INEXACT_BIT] = opLive && isArith && inexactResult;
  end

  assign unmaskedNew = newExc & ~control_reg[5:0];
  assign maskLoad = opLive && (opcode == OP_LOAD_CONTROL_WORD || opcode == OP_FULL_STATE_RESTORE
                    || opcode == OP_EXT_STATE_RESTORE);

  // APB decode; slave answers in the access cycle, no wait states.
  // Ready is tied high because every register is a plain flop or a
  // mux of flops, so the read path settles well inside one period.
  // Unmapped addresses answer with an error and read as zero; a
  // write there changes nothing, so stray software cannot disturb
  // the flags. The control register write is meant for test only:
  // in normal use the masks change through the load ops alone.
  // The clear register is write-only; only bit 0 has an effect.
  // Address decode compares the full byte address, so unaligned
  // accesses fall into the unmapped case as well.
  // Trade-off: no byte strobes, a word write replaces the whole
  // control word, which keeps the decode small.
  assign apbAccess = psel && penable;
  assign apbWrite = apbAccess && pwrite;
  assign mapped = (paddr == REG_STATUS) || (paddr == REG_CONTROL) || (paddr == REG_LAST_OP)
                  || (paddr == REG_CLEAR);
  assign apbClear = apbWrite && (paddr == REG_CLEAR) && pwdata[0];
  assign apbCtrlWrite = apbWrite && (paddr == REG_CONTROL);
  assign pready = 1'b1;
  assign pslverr = apbAccess && !mapped;

  // Flags after this cycle's clear, with new events winning over the clear
  assign flagsAfter = ((apbClear || (opLive && opcode == OP_CLEAR_EXC)) ? 6'h00 : status_reg[5:0])
                      | newExc;

  // Status word: sticky flags, stack fault, summary and direction bit
  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_reg <= STATUS_RESET;
    end else if (maskLoad && (opcode != OP_LOAD_CONTROL_WORD)) begin
      // Restores reload the environment; status is cleared, but a
      // fault raised in the same cycle still wins over the clear
      status_reg <= STATUS_RESET;
      status_reg[5:0] <= newExc;
      if (stackFault) begin
        status_reg[ST_STACK_FAULT_BIT] <= 1'b1;
        status_reg[ST_COND_ONE_BIT] <= stackOverflow;
      end
    end else begin
      status_reg[5:0] <= flagsAfter;
      if (stackFault) begin
        status_reg[ST_STACK_FAULT_BIT] <= 1'b1;
        status_reg[ST_COND_ONE_BIT] <= stackOverflow;
      end else if (apbClear || (opLive && opcode == OP_CLEAR_EXC)) begin
        status_reg[ST_STACK_FAULT_BIT] <= 1'b0; // Invalid operand never clears it
      end
      status_reg[ST_SUMMARY_BIT] <= |(flagsAfter & ~control_reg[5:0]) || (|unmaskedNew);
    end
  end

  // Control word: masks change only by the load ops, or by software test access
  always_ff @(posedge core_clk) begin
    if (reset) begin
      control_reg <= CTRL_RESET;
    end else if (maskLoad) begin
      control_reg <= opData;
    end else if (apbCtrlWrite) begin
      control_reg <= pwdata[15:0];
    end
  end

  // Store and save ops read masks or flags
  always_ff @(posedge core_clk) begin
    if (reset) begin
      storeData_reg <= 16'h0000;
      storeValid_reg <= 1'b0;
    end else begin
      storeValid_reg <= 1'b0;
      if (opLive && (opcode == OP_STORE_CONTROL_WORD)) begin
        storeData_reg <= control_reg;
        storeValid_reg <= 1'b1;
      end else if (opLive && (opcode == OP_STORE_STATUS_WORD || opcode == OP_FULL_STATE_SAVE
                   || opcode == OP_EXT_STATE_SAVE)) begin
        storeData_reg <= status_reg;
        storeValid_reg <= 1'b1;
      end
    end
  end

  // Save ops return only the status word, on the following cycle
  assign storeValid = storeValid_reg;
  assign storeData = storeData_reg;

  // Last accepted opcode, for software visibility
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lastOp_reg <= 5'h00;
    end else if (opLive) begin
      lastOp_reg <= opcode;
    end
  end

  // Masked stack fault: destination gets the indefinite value
  always_ff @(posedge core_clk) begin
    if (reset) begin
      writeIndef_reg <= 1'b0;
    end else begin
      writeIndef_reg <= stackFault && control_reg[ST_INVALID_BIT];
    end
  end
  assign writeIndefinite = writeIndef_reg;

  // Handler sequencing: an unmasked invalid holds stack state until done
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (unmaskedNew[ST_INVALID_BIT]) begin
          state_next = ST_HANDLER;
        end
      end
      ST_HANDLER: begin
        if (handlerDone) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // While the handler runs no new opcode is accepted
  assign handlerReq = (state_reg == ST_HANDLER);
  assign holdState = (state_reg == ST_HANDLER) || unmaskedNew[ST_INVALID_BIT];

  // APB read mux, unmapped reads zero
  always_comb begin
    prdata = 32'h00000000;
    if (apbAccess && !pwrite) begin
      case (paddr)
        REG_STATUS: prdata = {16'h0000, status_reg};
        REG_CONTROL: prdata = {16'h0000, control_reg};
        REG_LAST_OP: prdata = {27'h0000000, lastOp_reg};
        default: prdata = 32'h00000000;
      endcase
    end
  end
endmodule : fxu_exception_unit
`default_nettype wire

// ===== fxu_exception_unit_properties.sv
// Checker for the exception flag and mask unit's ports.
// Assumes one clock domain and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fxu_exception_unit_properties
  import fxu_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic reset, // Reset
  input wire logic opValid, // Opcode valid
  input wire fxu_op_t opcode, // Opcode class
  input wire logic stackOverflow, // Stack overflow
  input wire logic stackUnderflow, // Stack underflow
  input wire logic handlerDone, // Handler end
  input wire logic storeValid, // Store pulse
  input wire logic handlerReq, // Handler level
  input wire logic holdState, // Keep state
  input wire logic writeIndefinite, // Indefinite pulse
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic [11:0] paddr, // APB address
  input wire logic pready, // APB ready
  input wire logic pslverr // APB error
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic take;
  logic legacy;
  // Ops are refused while the handler runs
  assign take = opValid && !handlerReq;
  assign legacy = opcode inside {OP_LEGACY_INT_ENABLE, OP_LEGACY_INT_DISABLE, OP_LEGACY_PROTMODE_SET};
  property p_store; take && opcode inside {OP_STORE_STATUS_WORD, OP_STORE_CONTROL_WORD} |=> storeValid; endproperty
  a_store: assert property (p_store) else $error("store op gave no store pulse");
  property p_legacy; take && legacy |=> !storeValid && !writeIndefinite && !handlerReq; endproperty
  a_legacy: assert property (p_legacy) else $error("legacy op had an effect");
  property p_nonarith; take && opcode == OP_LOAD_REG && !stackOverflow && !stackUnderflow |=> !handlerReq; endproperty
  a_nonarith: assert property (p_nonarith) else $error("non-arithmetic op raised operand fault");
  property p_stack; take && !legacy && (stackOverflow || stackUnderflow) |=> handlerReq || writeIndefinite; endproperty
  a_stack: assert property (p_stack) else $error("stack fault not acted on");
  property p_hold; handlerReq |-> holdState; endproperty
  a_hold: assert property (p_hold) else $error("state not held in handler");
  property p_stay; handlerReq && !handlerDone |=> handlerReq; endproperty
  a_stay: assert property (p_stay) else $error("handler left early");
  property p_indef; writeIndefinite |-> !handlerReq && $past(stackOverflow || stackUnderflow); endproperty
  a_indef: assert property (p_indef) else $error("indefinite write without masked stack fault");
  property p_err; psel && penable && paddr > REG_CLEAR |-> pslverr && pready; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule : fxu_exception_unit_properties
bind fxu_exception_unit fxu_exception_unit_properties chk_u (.core_clk(core_clk), .reset(reset),
  .opValid(opValid), .opcode(opcode), .stackOverflow(stackOverflow), .stackUnderflow(stackUnderflow),
  .handlerDone(handlerDone), .storeValid(storeValid), .handlerReq(handlerReq), .holdState(holdState),
  .writeIndefinite(writeIndefinite), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr));
`default_nettype wire

// ===== fxu_exception_unit_test.sv
// Self-checking bench for the exception flag and mask unit.
// Assumes the core model ends handlers; this module is the APB master.
`timescale 1ns/1ps
`default_nettype none
module fxu_exception_unit_test
  import fxu_pkg::*;
;
  logic core_clk = 1'b0, reset = 1'b1, opValid = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  fxu_op_t opcode = OP_NONE;
  logic [15:0] opData = 16'h0000, storeData;
  logic [7:0] cond = 8'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] doneDelay = 4'h6;
  logic storeValid, handlerReq, holdState, writeIndefinite, pready, pslverr, handlerDone, err;
  int nFail = 0, nChecks = 0;
  always #2.5 core_clk = ~core_clk;
  // Condition bits: invalid, denorm, zerodiv, ovf, unf, inexact, stack ovf, stack unf
  fxu_exception_unit dut_u (.core_clk(core_clk), .reset(reset), .opValid(opValid), .opcode(opcode),
    .opData(opData), .stackOverflow(cond[6]), .stackUnderflow(cond[7]), .invalidOperand(cond[0]),
    .denormOperand(cond[1]), .zeroDivide(cond[2]), .numOverflow(cond[3]), .numUnderflow(cond[4]),
    .inexactResult(cond[5]), .handlerDone(handlerDone), .storeValid(storeValid), .storeData(storeData),
    .handlerReq(handlerReq), .holdState(holdState), .writeIndefinite(writeIndefinite), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));
  fxu_core_model core_u (.core_clk(core_clk), .reset(reset), .handlerReq(handlerReq), .doneDelay(doneDelay),
    .handlerDone(handlerDone));
  task automatic endOfTest;
    $display("checks %0d fails %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : endOfTest
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  // Answer is taken at the rising edge that samples pready high, never on a falling edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      nFail++;
      endOfTest();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic op(input fxu_op_t o, input logic [7:0] c, input logic [15:0] d);
    @(posedge core_clk);
    opValid <= 1'b1;
    opcode <= o;
    cond <= c;
    opData <= d;
    @(posedge core_clk);
    opValid <= 1'b0;
    cond <= 8'h00;
    #1;
  endtask : op
  task automatic stat(input logic [31:0] exp);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    check(rd, exp);
  endtask : stat
  task automatic testReset;
    stat(32'h0000_0000);
    apb(1'b0, REG_CONTROL, 32'h0000_0000);
    check(rd, {16'h0000, CTRL_RESET});
    apb(1'b0, 12'h010, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
  endtask : testReset
  task automatic testClasses;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, REG_CLEAR, 32'h0000_0001);
      op(OP_OTHER_ARITH, 8'h01 << i, 16'h0000);
      stat(32'h0000_0001 << i);
    end
  endtask : testClasses
  task automatic testClassify;
    fxu_op_t ops[8] = '{OP_LOAD_REG, OP_LOAD_EXTENDED_MEM, OP_LOAD_CONSTANT, OP_LOAD_SINGLE_DOUBLE,
      OP_STORE_REG, OP_STORE_POP_EXTENDED, OP_STORE_SINGLE_DOUBLE, OP_TRUNC_INT_STORE_POP};
    logic [7:0] arith = 8'hC8;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, REG_CLEAR, 32'h0000_0001);
      op(ops[i], 8'h22, 16'h0000);
      stat(arith[i] ? 32'h0000_0022 : 32'h0000_0000);
    end
  endtask : testClassify
  task automatic testStack;
    apb(1'b1, REG_CLEAR, 32'h0000_0001);
    op(OP_LOAD_REG, 8'h40, 16'h0000);
    check({31'h0, writeIndefinite}, 32'h0000_0001);
    stat(32'h0000_0241);
    apb(1'b1, REG_CLEAR, 32'h0000_0001);
    op(OP_STORE_REG, 8'h80, 16'h0000);
    check({31'h0, writeIndefinite}, 32'h0000_0001);
    stat(32'h0000_0041);
  endtask : testStack
  task automatic testHandler;
    int n;
    op(OP_LOAD_CONTROL_WORD, 8'h00, 16'h037E);
    op(OP_STORE_CONTROL_WORD, 8'h00, 16'h0000);
    check({15'h0, storeValid, storeData}, 32'h0001_037E);
    apb(1'b1, REG_CLEAR, 32'h0000_0001);
    for (int i = 1; i < 4; i++) op(fxu_op_t'(i), 8'hFF, 16'h0000);
    check({31'h0, handlerReq}, 32'h0000_0000);
    stat(32'h0000_0000);
    op(OP_OTHER_ARITH, 8'h01, 16'h0000);
    check({30'h0, handlerReq, holdState}, 32'h0000_0003);
    op(OP_STORE_STATUS_WORD, 8'h00, 16'h0000);
    check({31'h0, storeValid}, 32'h0000_0000);
    n = 0;
    while (handlerReq && n < 50) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check({31'h0, handlerReq}, 32'h0000_0000);
    stat(32'h0000_0081);
    op(OP_FULL_STATE_SAVE, 8'h00, 16'h0000);
    check({16'h0, storeData}, 32'h0000_0081);
    op(OP_EXT_STATE_RESTORE, 8'h00, 16'h037F);
    apb(1'b0, REG_CONTROL, 32'h0000_0000);
    check(rd, 32'h0000_037F);
    apb(1'b0, REG_LAST_OP, 32'h0000_0000);
    check(rd, {27'h0000000, OP_EXT_STATE_RESTORE});
  endtask : testHandler
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    testReset();
    testClasses();
    testClassify();
    testStack();
    testHandler();
    endOfTest();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    nFail++;
    endOfTest();
  end
endmodule : fxu_exception_unit_test
`default_nettype wire

// ===== fxu_op_classifier.sv
// Per-opcode lookup of the arithmetic class.
// Assumes the opcode is presented from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fxu_op_classifier
  import fxu_pkg::*;
(
  input wire fxu_op_t opcode, // Decoded opcode class
  output logic isArith, // Operand-derived exceptions apply
  output logic isLegacyNop // Legacy opcode, no effect
);
  // Fixed table: anything not listed is non-arithmetic
  always_comb begin
    isLegacyNop = 1'b0;
    case (opcode)
      OP_LOAD_SINGLE_DOUBLE: isArith = 1'b1;
      OP_STORE_SINGLE_DOUBLE: isArith = 1'b1;
      OP_TRUNC_INT_STORE_POP: isArith = 1'b1;
      OP_OTHER_ARITH: isArith = 1'b1;
      OP_LEGACY_INT_ENABLE, OP_LEGACY_INT_DISABLE, OP_LEGACY_PROTMODE_SET: begin
        isArith = 1'b0;
        isLegacyNop = 1'b1;
      end
      default: isArith = 1'b0;
    endcase
  end
endmodule : fxu_op_classifier
`default_nettype wire

// ===== fxu_pkg.sv
// Package for the floating-point exception flag and mask unit.
// Assumes a single core clock and a synchronous active-high reset.
package fxu_pkg;
  // Status word field positions
  localparam int ST_INVALID_BIT = 0;
  localparam int ST_DENORM_BIT = 1;
  localparam int ST_ZERODIV_BIT = 2;
  localparam int ST_OVERFLOW_BIT = 3;
  localparam int ST_UNDERFLOW_BIT = 4;
  localparam int ST_INEXACT_BIT = 5;
  localparam int ST_STACK_FAULT_BIT = 6;
  localparam int ST_SUMMARY_BIT = 7;
  localparam int ST_COND_ONE_BIT = 9;
  localparam int EXC_CLASSES = 6;
  // Control word reset value: all six classes masked
  localparam logic [15:0] CTRL_RESET = 16'h037F;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [5:0] EXC_MASK_FIELD = 6'h3F;
  // APB register byte addresses
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_CONTROL = 12'h004;
  localparam logic [11:0] REG_LAST_OP = 12'h008;
  localparam logic [11:0] REG_CLEAR = 12'h00C;
  // Opcode classes of the instruction stream
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_LEGACY_INT_ENABLE = 5'h01,
    OP_LEGACY_INT_DISABLE = 5'h02,
    OP_LEGACY_PROTMODE_SET = 5'h03,
    OP_LOAD_CONTROL_WORD = 5'h04,
    OP_FULL_STATE_RESTORE = 5'h05,
    OP_EXT_STATE_RESTORE = 5'h06,
    OP_STORE_CONTROL_WORD = 5'h07,
    OP_STORE_STATUS_WORD = 5'h08,
    OP_FULL_STATE_SAVE = 5'h09,
    OP_EXT_STATE_SAVE = 5'h0A,
    OP_LOAD_REG = 5'h0B,
    OP_LOAD_EXTENDED_MEM = 5'h0C,
    OP_LOAD_CONSTANT = 5'h0D,
    OP_LOAD_SINGLE_DOUBLE = 5'h0E,
    OP_STORE_REG = 5'h0F,
    OP_STORE_POP_EXTENDED = 5'h10,
    OP_STORE_SINGLE_DOUBLE = 5'h11,
    OP_TRUNC_INT_STORE_POP = 5'h12,
    OP_OTHER_ARITH = 5'h13,
    OP_OTHER_NONARITH = 5'h14,
    OP_CLEAR_EXC = 5'h15
  } fxu_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HANDLER = 2'b01
  } fxu_state_t;
endpackage : fxu_pkg
